// ===== src/bsfs_pkg.sv
// bsfs_pkg: shared constants of the bus-frequency-select and sync block.
// assumes nothing beyond a SystemVerilog compiler.
package bsfs_pkg;
  localparam logic [1:0] FREQ_CODE_133    = 2'h3;
  localparam int         BUS_RATED_MHZ    = 133;
  localparam int         REF_CLK_MHZ      = 100;
  localparam int         SYNC_STAGES      = 2;
  localparam int         ADDR_W_DEF       = 33;
  localparam int         DATA_W_DEF       = 64;
  localparam int         IRQ_W            = 2;
  localparam int         CTRL_W           = 4;
  localparam int         CTRL_PRIO_BIT    = 0;
  localparam int         CTRL_TRANSACTION_A_BIT   = 1;
  localparam int         CTRL_RESET_BIT   = 2;
  localparam int         CTRL_PARITY_BIT  = 3;
  localparam logic       OD_LEVEL         = 1'b0;
endpackage

// ===== src/bsfs_sync.sv
// bsfs_sync: two-flop synchroniser with edge strobes for one async pin.
// assumes async_in has no phase relation to clk_in.
`timescale 1ns/1ps
`default_nettype none
module bsfs_sync
  import bsfs_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  rst_in,
  input  wire logic  en_in,
  input  wire logic  async_in,
  bsfs_sync_if.prod  sync
);
  logic meta_r;
  logic lvl_r;
  logic old_r;

  // meta_r feeds lvl_r only; edges come from the settled stages
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= 1'b0;
      lvl_r  <= 1'b0;
      old_r  <= 1'b0;
    end else if (en_in) begin
      meta_r <= async_in;
      lvl_r  <= meta_r;
      old_r  <= lvl_r;
    end
  end

  assign sync.level = lvl_r;
  assign sync.rise  = lvl_r & ~old_r;
  assign sync.fall  = ~lvl_r & old_r;
endmodule
`default_nettype wire

// ===== src/bsfs_sync_if.sv
// bsfs_sync_if: synchronised level and its edge strobes.
// assumes one clock shared by producer and consumer.
`timescale 1ns/1ps
`default_nettype none
interface bsfs_sync_if;
  logic level;
  logic rise;
  logic fall;
  modport prod (output level, output rise, output fall);
  modport cons (input level, input rise, input fall);
endinterface
`default_nettype wire

// ===== src/bsfs_top.sv
// bsfs_top: bus frequency select outputs and per-domain pin handling.
// assumes ref_clk_in is the system bus clock; other clocks arrive as pins.
`timescale 1ns/1ps
`default_nettype none
module bsfs_top
  import bsfs_pkg::*;
#(
  parameter int         ADDR_W    = ADDR_W_DEF,
  parameter int         DATA_W    = DATA_W_DEF,
  parameter logic [1:0] FREQ_CODE = FREQ_CODE_133
)(
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic              clk_en_in,
  input  wire logic              termination_power_good_in,
  output var  logic [1:0]        bus_freq_select_out,
  output var  logic [1:0]        bus_freq_select_oe_out,
  output var  logic              freq_stable_out,
  input  wire logic              bus_req_in,
  input  wire logic              bus_request_zero_in,
  output var  logic              bus_request_zero_out,
  output var  logic              bus_request_zero_oe_out,
  input  wire logic              bus_request_line_in,
  output var  logic [1:0]        bus_req_seen_out,
  input  wire logic              priority_agent_request_in,
  input  wire logic              transaction_a_in,
  input  wire logic              bus_reset_in,
  input  wire logic              response_parity_in,
  output var  logic [CTRL_W-1:0] ctrl_seen_out,
  input  wire logic              drive_in,
  input  wire logic [ADDR_W-1:0] addr_wr_in,
  input  wire logic [DATA_W-1:0] data_wr_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] data_in,
  output var  logic [ADDR_W-1:0] addr_out,
  output var  logic [DATA_W-1:0] data_out,
  output var  logic              addr_data_oe_out,
  output var  logic [ADDR_W-1:0] addr_rd_out,
  output var  logic [DATA_W-1:0] data_rd_out,
  input  wire logic              interrupt_bus_clock_in,
  input  wire logic [IRQ_W-1:0]  interrupt_bus_data_in,
  input  wire logic [IRQ_W-1:0]  irq_tx_in,
  output var  logic [IRQ_W-1:0]  interrupt_bus_data_out,
  output var  logic [IRQ_W-1:0]  interrupt_bus_data_oe_out,
  output var  logic [IRQ_W-1:0]  irq_rx_out,
  input  wire logic              tck_in,
  input  wire logic              tdi_in,
  input  wire logic              tms_in,
  input  wire logic              trst_n_in,
  output var  logic              tdo_out,
  output var  logic              tms_seen_out
);
  // reserved codes would put the platform on an undefined frequency
  if (FREQ_CODE != FREQ_CODE_133) begin : g_bad_code
    $error("frequency code must select the rated bus frequency");
  end
  if (ADDR_W < 1 || DATA_W < 1) begin : g_bad_width
    $error("address and data widths must be positive");
  end

  bsfs_sync_if pg_s ();
  bsfs_sync_if ick_s ();
  bsfs_sync_if tck_s ();
  bsfs_sync_if trst_s ();

  bsfs_sync u_pg (.clk_in(ref_clk_in), .rst_in(rst_in), .en_in(clk_en_in),
    .async_in(termination_power_good_in), .sync(pg_s));
  bsfs_sync u_ick (.clk_in(ref_clk_in), .rst_in(rst_in), .en_in(clk_en_in),
    .async_in(interrupt_bus_clock_in), .sync(ick_s));
  bsfs_sync u_tck (.clk_in(ref_clk_in), .rst_in(rst_in), .en_in(clk_en_in),
    .async_in(tck_in), .sync(tck_s));
  bsfs_sync u_trst (.clk_in(ref_clk_in), .rst_in(rst_in), .en_in(clk_en_in),
    .async_in(~trst_n_in), .sync(trst_s));

  // data pins of slow domains also pass two flops before use
  logic [IRQ_W-1:0] irq_m_r;
  logic [IRQ_W-1:0] irq_s_r;
  logic [1:0]       tap_m_r;
  logic [1:0]       tap_s_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_m_r <= '1;
      irq_s_r <= '1;
      tap_m_r <= 2'h0;
      tap_s_r <= 2'h0;
    end else if (clk_en_in) begin
      irq_m_r <= interrupt_bus_data_in;
      irq_s_r <= irq_m_r;
      tap_m_r <= {tms_in, tdi_in};
      tap_s_r <= tap_m_r;
    end
  end

  // open-drain code pins: a one is released to the pull-up, a zero driven
  wire [1:0] fsel_oe_nxt = ~FREQ_CODE;
  wire       stable_nxt  = freq_stable_out | pg_s.level;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_freq_select_out    <= {2{OD_LEVEL}};
      bus_freq_select_oe_out <= 2'h0;
      freq_stable_out        <= 1'b0;
    end else if (clk_en_in) begin
      bus_freq_select_out    <= {2{OD_LEVEL}};
      bus_freq_select_oe_out <= fsel_oe_nxt;
      freq_stable_out        <= stable_nxt;
    end
  end

  // bus group registered on the bus clock only
  wire [CTRL_W-1:0] ctrl_nxt = {response_parity_in, bus_reset_in,
                                transaction_a_in, priority_agent_request_in};
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_request_zero_out    <= OD_LEVEL;
      bus_request_zero_oe_out <= 1'b0;
      bus_req_seen_out        <= 2'h0;
      ctrl_seen_out           <= '0;
      addr_out                <= '0;
      data_out                <= '0;
      addr_data_oe_out        <= 1'b0;
      addr_rd_out             <= '0;
      data_rd_out             <= '0;
    end else if (clk_en_in) begin
      bus_request_zero_out    <= OD_LEVEL;
      bus_request_zero_oe_out <= bus_req_in;
      bus_req_seen_out        <= {bus_request_line_in,
                                  bus_request_zero_in};
      ctrl_seen_out           <= ctrl_nxt;
      addr_out                <= addr_wr_in;
      data_out                <= data_wr_in;
      addr_data_oe_out        <= drive_in;
      if (!drive_in) begin
        addr_rd_out <= addr_in;
        data_rd_out <= data_in;
      end
    end
  end

  // interrupt bus: sample on its rising edge, change drive on its falling
  // edge; pin rate must stay well below a quarter of the bus clock
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      interrupt_bus_data_out    <= {IRQ_W{OD_LEVEL}};
      interrupt_bus_data_oe_out <= '0;
      irq_rx_out                <= '1;
    end else if (clk_en_in) begin
      interrupt_bus_data_out <= {IRQ_W{OD_LEVEL}};
      if (ick_s.fall)
        interrupt_bus_data_oe_out <= ~irq_tx_in;
      if (ick_s.rise)
        irq_rx_out <= irq_s_r;
    end
  end

  // test port: one-bit bypass path, tdi caught on rise, tdo moved on fall
  logic tap_bit_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tap_bit_r    <= 1'b0;
      tdo_out      <= 1'b0;
      tms_seen_out <= 1'b0;
    end else if (clk_en_in) begin
      if (trst_s.level) begin
        tap_bit_r    <= 1'b0;
        tdo_out      <= 1'b0;
        tms_seen_out <= 1'b0;
      end else begin
        if (tck_s.rise) begin
          tap_bit_r    <= tap_s_r[0];
          tms_seen_out <= tap_s_r[1];
        end
        if (tck_s.fall)
          tdo_out <= tap_bit_r;
      end
    end
  end

  a_code_released: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    clk_en_in |=> bus_freq_select_oe_out == ~FREQ_CODE)
    else $error("frequency code pins not at the selected code");
  a_stable_after_pg: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    $rose(pg_s.level) && clk_en_in |=> freq_stable_out)
    else $error("code not marked stable after power good");
  a_stable_holds: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    freq_stable_out |=> freq_stable_out && $stable(bus_freq_select_oe_out))
    else $error("frequency code changed after it was stable");
  // both conditions must hold on the same three edges, or the flops freeze
  a_pg_two_flops: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    (clk_en_in && termination_power_good_in) [*3] |=> freq_stable_out)
    else $error("power good not seen within three cycles");
  a_br0_follows: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    clk_en_in |=> bus_request_zero_oe_out == $past(bus_req_in)
                  && !bus_request_zero_out)
    else $error("request zero drive does not follow the request");
  a_rd_hold: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    clk_en_in && drive_in |=> $stable(addr_rd_out) && $stable(data_rd_out))
    else $error("captured bus input changed while driving");
  a_ctrl_sample: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    clk_en_in |=> ctrl_seen_out == $past(ctrl_nxt))
    else $error("input-only bus lines not sampled on the bus clock");
  a_irq_edge_only: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    !ick_s.rise |=> $stable(irq_rx_out))
    else $error("interrupt data sampled off its clock edge");
  a_irq_sample: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    ick_s.rise && clk_en_in |=> irq_rx_out == $past(irq_s_r))
    else $error("interrupt data not taken on its rising edge");
  a_irq_drive: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    ick_s.fall && clk_en_in
    |=> interrupt_bus_data_oe_out == ~$past(irq_tx_in))
    else $error("interrupt data drive not updated on falling edge");
  a_tdo_on_fall: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    !tck_s.fall && !trst_s.level |=> $stable(tdo_out))
    else $error("test output moved off the test clock falling edge");
  a_trst_clears: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    trst_s.level && clk_en_in |=> !tdo_out && !tms_seen_out)
    else $error("test reset did not clear the test port");
  a_freeze: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    !clk_en_in |=> $stable(irq_rx_out) && $stable(tdo_out)
                   && $stable(addr_data_oe_out))
    else $error("state moved while clock enable was low");
endmodule
`default_nettype wire

// ===== testbench/bsfs_clkgen_model.sv
// bsfs_clkgen_model: bus clock generator seen from the select pins.
// assumes the bench resolves the open-drain select wires with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module bsfs_clkgen_model (
  input  wire logic       ref_clk_in,
  input  wire logic       pwr_good_in,
  input  wire logic [1:0] sel_wire_in,
  output var  logic [1:0] code_out,
  output var  logic       locked_out
);
  // one capture per power-good assertion; later pin changes are ignored
  always_ff @(posedge ref_clk_in or negedge pwr_good_in) begin
    if (!pwr_good_in) begin
      locked_out <= 1'b0;
      code_out   <= 2'h0;
    end else if (!locked_out) begin
      locked_out <= 1'b1;
      code_out   <= sel_wire_in;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/bsfs_top_tb.sv
// bsfs_top_tb: random and corner stimulus for bsfs_top with a clock generator.
// assumes the design's default widths and the package frequency code.
`timescale 1ns/1ps
`default_nettype none
module bsfs_top_tb
  import bsfs_pkg::*;
;
  logic ref_clk_in, rst_in, clk_en_in, termination_power_good_in, bus_req_in;
  logic bus_request_zero_in, bus_request_line_in, priority_agent_request_in;
  logic transaction_a_in, bus_reset_in, response_parity_in, drive_in;
  logic interrupt_bus_clock_in, tck_in, tdi_in, tms_in, trst_n_in;
  logic freq_stable_out, bus_request_zero_out, bus_request_zero_oe_out;
  logic addr_data_oe_out, tdo_out, tms_seen_out, gen_locked;
  logic [1:0] bus_freq_select_out, bus_freq_select_oe_out, bus_req_seen_out;
  logic [1:0] interrupt_bus_data_in, irq_tx_in, interrupt_bus_data_out;
  logic [1:0] interrupt_bus_data_oe_out, irq_rx_out, sel_wire, gen_code, d, t;
  logic [CTRL_W-1:0] ctrl_seen_out;
  logic [ADDR_W_DEF-1:0] addr_wr_in, addr_in, addr_out, addr_rd_out;
  logic [DATA_W_DEF-1:0] data_wr_in, data_in, data_out, data_rd_out;
  logic [74:0] e_bus;
  logic [127:0] e_dat;
  int mismatches, check_count;

  bsfs_top DUT (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
    .termination_power_good_in(termination_power_good_in),
    .bus_freq_select_out(bus_freq_select_out),
    .bus_freq_select_oe_out(bus_freq_select_oe_out),
    .freq_stable_out(freq_stable_out), .bus_req_in(bus_req_in),
    .bus_request_zero_in(bus_request_zero_in),
    .bus_request_zero_out(bus_request_zero_out),
    .bus_request_zero_oe_out(bus_request_zero_oe_out),
    .bus_request_line_in(bus_request_line_in),
    .bus_req_seen_out(bus_req_seen_out),
    .priority_agent_request_in(priority_agent_request_in),
    .transaction_a_in(transaction_a_in), .bus_reset_in(bus_reset_in),
    .response_parity_in(response_parity_in), .ctrl_seen_out(ctrl_seen_out),
    .drive_in(drive_in), .addr_wr_in(addr_wr_in), .data_wr_in(data_wr_in),
    .addr_in(addr_in), .data_in(data_in), .addr_out(addr_out),
    .data_out(data_out), .addr_data_oe_out(addr_data_oe_out),
    .addr_rd_out(addr_rd_out), .data_rd_out(data_rd_out),
    .interrupt_bus_clock_in(interrupt_bus_clock_in),
    .interrupt_bus_data_in(interrupt_bus_data_in), .irq_tx_in(irq_tx_in),
    .interrupt_bus_data_out(interrupt_bus_data_out),
    .interrupt_bus_data_oe_out(interrupt_bus_data_oe_out),
    .irq_rx_out(irq_rx_out), .tck_in(tck_in), .tdi_in(tdi_in),
    .tms_in(tms_in), .trst_n_in(trst_n_in), .tdo_out(tdo_out),
    .tms_seen_out(tms_seen_out)
  );
  // open-drain select pins with board pull-ups
  assign sel_wire = ~bus_freq_select_oe_out
                  | (bus_freq_select_oe_out & bus_freq_select_out);
  bsfs_clkgen_model GEN (
    .ref_clk_in  (ref_clk_in),
    .pwr_good_in (termination_power_good_in),
    .sel_wire_in (sel_wire),
    .code_out    (gen_code),
    .locked_out  (gen_locked)
  );

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // open-drain send: a one leaves the pin released, a zero pulls it low
  function automatic logic [1:0] irq_oe_exp(input logic [1:0] tx);
    return ~tx;
  endfunction

  task automatic summarize();
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    {rst_in, clk_en_in, trst_n_in} = 3'h7;
    {termination_power_good_in, bus_req_in, bus_request_zero_in} = 3'h0;
    {bus_request_line_in, priority_agent_request_in, transaction_a_in} = 3'h0;
    {bus_reset_in, response_parity_in, drive_in} = 3'h0;
    {tck_in, tdi_in, tms_in} = 3'h0;
    {interrupt_bus_clock_in, interrupt_bus_data_in, irq_tx_in} = 5'h00;
    {addr_wr_in, addr_in, data_wr_in, data_in} = '0;
    e_bus = '0;
    e_dat = '0;
    mismatches = 0;
    check_count = 0;
    void'($urandom(32'h8284));
    repeat (16) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk(irq_rx_out, 2'h3);
    chk({freq_stable_out, bus_freq_select_oe_out}, 3'h0);
    rst_in = 1'b0;
    @(negedge ref_clk_in);
    chk({bus_freq_select_oe_out, bus_freq_select_out, interrupt_bus_data_out},
        {~FREQ_CODE_133, 4'h0});
    termination_power_good_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    chk(freq_stable_out, 1'b0);
    @(negedge ref_clk_in);
    chk({freq_stable_out, sel_wire}, {1'b1, FREQ_CODE_133});
    chk({gen_locked, gen_code}, {1'b1, FREQ_CODE_133});
    for (int i = 0; i < 400; i++) begin
      chk({bus_request_zero_out, bus_request_zero_oe_out, bus_req_seen_out,
           ctrl_seen_out, addr_data_oe_out, addr_out, addr_rd_out},
          e_bus);
      chk({data_out, data_rd_out}, e_dat);
      {bus_req_in, bus_request_zero_in, bus_request_line_in} = 3'($urandom);
      drive_in = (i < 6) || ($urandom % 2 != 0);
      {priority_agent_request_in, transaction_a_in, bus_reset_in,
       response_parity_in} = 4'($urandom);
      // forced stall every fifty cycles besides the random ones
      clk_en_in = (i % 50 != 20) && ($urandom % 8 != 0);
      addr_wr_in = ADDR_W_DEF'({$urandom, $urandom});
      addr_in = (i == 3) ? '1 : ADDR_W_DEF'({$urandom, $urandom});
      data_wr_in = {$urandom, $urandom};
      data_in = {$urandom, $urandom};
      if (clk_en_in) begin
        e_bus = {1'b0, bus_req_in, bus_request_line_in, bus_request_zero_in,
                 response_parity_in, bus_reset_in, transaction_a_in,
                 priority_agent_request_in, drive_in, addr_wr_in,
                 drive_in ? e_bus[32:0] : addr_in};
        e_dat = {data_wr_in, drive_in ? e_dat[63:0] : data_in};
      end
      @(negedge ref_clk_in);
    end
    clk_en_in = 1'b1;
    for (int i = 0; i < 8; i++) begin
      d = (i < 4) ? 2'(i) : 2'($urandom);
      t = 2'($urandom);
      {interrupt_bus_data_in, irq_tx_in} = {d, t};
      {tdi_in, tms_in} = (i == 7) ? 2'h3 : 2'($urandom);
      repeat (5) @(negedge ref_clk_in);
      {interrupt_bus_clock_in, tck_in} = 2'h3;
      repeat (5) @(negedge ref_clk_in);
      chk(irq_rx_out, d);
      chk(tms_seen_out, tms_in);
      {interrupt_bus_clock_in, tck_in} = 2'h0;
      repeat (5) @(negedge ref_clk_in);
      chk(interrupt_bus_data_oe_out, irq_oe_exp(t));
      chk(tdo_out, tdi_in);
    end
    trst_n_in = 1'b0;
    repeat (5) @(negedge ref_clk_in);
    chk({tdo_out, tms_seen_out}, 2'h0);
    termination_power_good_in = 1'b0;
    repeat (5) @(negedge ref_clk_in);
    chk({freq_stable_out, sel_wire}, {1'b1, FREQ_CODE_133});
    rst_in = 1'b1;
    @(negedge ref_clk_in);
    chk(freq_stable_out, 1'b0);
    chk(gen_locked, 1'b0);
    // a second power-up after a mid-run reset must qualify the code again
    {rst_in, trst_n_in, termination_power_good_in} = 3'h3;
    repeat (2) @(negedge ref_clk_in);
    chk(freq_stable_out, 1'b0);
    @(negedge ref_clk_in);
    chk({freq_stable_out, sel_wire}, {1'b1, FREQ_CODE_133});
    chk({gen_locked, gen_code}, {1'b1, FREQ_CODE_133});
    summarize();
  end
endmodule
`default_nettype wire
